/* File: rtl/pmb_pkg.sv */
// constants for the program memory map and boot selection block
package pmb_pkg;
  localparam logic [15:0] PMB_ROM_BASE = 16'hf000;
  localparam logic [15:0] PMB_ROM_TOP = 16'hffff;
  localparam logic [15:0] PMB_USER_TOP = 16'h1fff;
  localparam logic [12:0] PMB_CFG_LAST = 13'h002f;
  localparam logic [12:0] PMB_FUSE_ADDR = 13'h1fcf;
  localparam logic [7:0] PMB_CFG_RAM_BASE = 8'h30;
  localparam logic [7:0] PMB_BLANK_LO = 8'h00;
  localparam logic [7:0] PMB_BLANK_HI = 8'hff;
  localparam int PMB_CFG_BYTES = 48;
  localparam int PMB_CFG_WORDS = 16;
  localparam logic [1:0] PMB_BYTES_PER_WORD = 2'h3;
  localparam int PMB_UEE_DEPTH = 128;
  typedef enum logic [1:0] {PMB_SEL_NONE, PMB_SEL_ROM, PMB_SEL_USER} pmb_region_t;
  typedef enum {PMB_ST_PROBE, PMB_ST_PROBE_WAIT, PMB_ST_LOAD, PMB_ST_LOAD_WAIT,
                PMB_ST_RUN} pmb_state_t;
endpackage : pmb_pkg

/* File: rtl/pmb_boot.sv */
// program memory map, otp protection, boot source select and config loader
`timescale 1ns/1ns
module pmb_boot
  import pmb_pkg::*;
#(
  parameter int OTP_DEPTH = 8192,
  parameter int EXT_DEPTH = 8192
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // core program fetch
  input wire logic [15:0] core_pc,
  input wire logic core_fetch,
  input wire logic [7:0] rom_rdata,
  output logic [7:0] core_instr,
  output logic core_in_rom,
  output logic core_reserved,
  input wire logic rom_return_cfg,
  output logic core_may_return,
  // external program eeprom byte port
  output logic ext_req,
  output logic [12:0] ext_addr,
  input wire logic ext_ack,
  input wire logic [7:0] ext_rdata,
  // serial command side
  input wire logic cmd_otp_program_enable_on,
  input wire logic cmd_otp_program_enable_off,
  input wire logic cmd_otp_wr,
  input wire logic cmd_otp_rd,
  input wire logic [12:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic otp_program_enable,
  output logic otp_unlocked,
  // config ram write port
  output logic cfg_we,
  output logic [7:0] cfg_addr,
  output logic [23:0] cfg_wdata,
  output logic boot_done,
  output logic boot_from_ext,
  // user eeprom, shared ram pointer
  input wire logic [7:0] ram_ptr,
  input wire logic uee_store,
  input wire logic uee_fetch,
  input wire logic [7:0] uee_wdata,
  output logic [7:0] uee_rdata
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] otp_mem [OTP_DEPTH];
  logic [OTP_DEPTH-1:0] otp_written_reg;
  logic [7:0] uee_mem [PMB_UEE_DEPTH];
  pmb_state_t state_reg;
  logic [5:0] load_idx_reg;
  logic [1:0] byte_cnt_reg;
  logic [23:0] word_reg;
  logic [3:0] word_idx_reg;
  logic prot_reg;
  pmb_region_t region;
  logic [12:0] load_addr;
  logic [7:0] load_byte;
  logic load_byte_ok;

  // unwritten otp cells read as zero, also for the config loader
  function automatic logic [7:0] otp_mem_rd(input logic [12:0] a);
    otp_mem_rd = otp_written_reg[a] ? otp_mem[a] : 8'h00;
  endfunction : otp_mem_rd

  assign region = (core_pc >= PMB_ROM_BASE) ? PMB_SEL_ROM :
                  (core_pc <= PMB_USER_TOP) ? PMB_SEL_USER : PMB_SEL_NONE;
  assign core_in_rom = (region == PMB_SEL_ROM);
  assign core_reserved = (region == PMB_SEL_NONE);
  assign core_may_return = core_in_rom && rom_return_cfg && boot_done;
  assign otp_unlocked = !prot_reg;
  assign load_addr = 13'(load_idx_reg);

  ////////////////////////////////////////////////////////////////////////
  // boot sequencer: probe external byte 0, then load 48 config bytes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PMB_ST_PROBE;
      boot_from_ext <= 1'b0;
      load_idx_reg <= 6'h00;
    end else begin
      case (state_reg)
        PMB_ST_PROBE: state_reg <= PMB_ST_PROBE_WAIT;
        PMB_ST_PROBE_WAIT: begin
          if (ext_ack) begin
            boot_from_ext <= (ext_rdata != PMB_BLANK_LO) && (ext_rdata != PMB_BLANK_HI);
            state_reg <= PMB_ST_LOAD;
          end
        end
        PMB_ST_LOAD: state_reg <= boot_from_ext ? PMB_ST_LOAD_WAIT : PMB_ST_LOAD;
        PMB_ST_LOAD_WAIT: state_reg <= ext_ack ? PMB_ST_LOAD : PMB_ST_LOAD_WAIT;
        PMB_ST_RUN: state_reg <= PMB_ST_RUN;
        default: state_reg <= PMB_ST_PROBE;
      endcase
      if (load_byte_ok) begin
        if (load_addr == PMB_CFG_LAST) begin
          state_reg <= PMB_ST_RUN;
        end else begin
          load_idx_reg <= load_idx_reg + 6'h01;
        end
      end
    end
  end

  assign load_byte_ok = (state_reg == PMB_ST_LOAD && !boot_from_ext) ||
                        (state_reg == PMB_ST_LOAD_WAIT && ext_ack);
  assign load_byte = boot_from_ext ? ext_rdata : otp_mem_rd(load_addr);
  assign boot_done = (state_reg == PMB_ST_RUN);

  // external port: probe and config loading, then core fetches
  always_comb begin
    ext_req = 1'b0;
    ext_addr = 13'h0000;
    case (state_reg)
      PMB_ST_PROBE, PMB_ST_PROBE_WAIT: ext_req = 1'b1;
      PMB_ST_LOAD_WAIT: begin
        ext_req = 1'b1;
        ext_addr = load_addr;
      end
      PMB_ST_RUN: begin
        ext_req = boot_from_ext && core_fetch && (region == PMB_SEL_USER);
        ext_addr = core_pc[12:0];
      end
      default: ext_req = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // assemble three bytes per word, first byte into bits 23:16
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_reg <= 2'h0;
      word_reg <= 24'h000000;
      word_idx_reg <= 4'h0;
      cfg_we <= 1'b0;
      cfg_addr <= 8'h00;
      cfg_wdata <= 24'h000000;
    end else begin
      cfg_we <= 1'b0;
      if (load_byte_ok) begin
        word_reg <= {word_reg[15:0], load_byte};
        if (byte_cnt_reg == PMB_BYTES_PER_WORD - 2'h1) begin
          byte_cnt_reg <= 2'h0;
          cfg_we <= 1'b1;
          cfg_wdata <= {word_reg[15:0], load_byte};
          cfg_addr <= PMB_CFG_RAM_BASE + {4'h0, word_idx_reg};
          word_idx_reg <= word_idx_reg + 4'h1;
        end else begin
          byte_cnt_reg <= byte_cnt_reg + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // otp programming enable and write-once store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_program_enable <= 1'b0;
    end else if (cmd_otp_program_enable_on) begin
      otp_program_enable <= 1'b1;
    end else if (cmd_otp_program_enable_off) begin
      otp_program_enable <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_written_reg <= '0;
    end else if (cmd_otp_wr && otp_program_enable && !otp_written_reg[cmd_addr]) begin
      otp_written_reg[cmd_addr] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cmd_otp_wr && otp_program_enable && !otp_written_reg[cmd_addr]) begin
      otp_mem[cmd_addr] <= cmd_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fuse protection: reading the fuse byte decides the protection state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_reg <= 1'b1;
    end else if (cmd_otp_rd && cmd_addr == PMB_FUSE_ADDR) begin
      prot_reg <= (otp_mem_rd(cmd_addr) != 8'h00);
    end
  end

  // answer to an otp read; fuse byte itself is always visible
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rvalid <= 1'b0;
      cmd_rdata <= 8'h00;
    end else begin
      cmd_rvalid <= cmd_otp_rd;
      if (cmd_otp_rd) begin
        if (cmd_addr == PMB_FUSE_ADDR) begin
          cmd_rdata <= otp_mem_rd(cmd_addr);
        end else if (prot_reg) begin
          cmd_rdata <= 8'h00;
        end else begin
          cmd_rdata <= otp_mem_rd(cmd_addr);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core instruction byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_instr <= 8'h00;
    end else if (core_fetch) begin
      case (region)
        PMB_SEL_ROM: core_instr <= rom_rdata;
        PMB_SEL_USER: core_instr <= boot_from_ext ? ext_rdata : otp_mem_rd(core_pc[12:0]);
        default: core_instr <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user eeprom addressed by the shared ram pointer
  always_ff @(posedge ref_clk) begin
    if (uee_store) begin
      uee_mem[ram_ptr[6:0]] <= uee_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uee_rdata <= 8'h00;
    end else if (uee_fetch) begin
      uee_rdata <= uee_mem[ram_ptr[6:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_rom_region: assert property (@(posedge ref_clk) disable iff (!rst_n)
    core_pc >= 16'hf000 |-> core_in_rom && !core_reserved)
    else $error("rom window not decoded");
  chk_reserved_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_pc > 16'h1fff && core_pc < 16'hf000) |-> core_reserved)
    else $error("reserved gap not flagged");
  chk_write_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(otp_written_reg[cmd_addr]) && cmd_otp_rd && $stable(cmd_addr) |=>
    cmd_rdata == $past(otp_mem_rd(cmd_addr)) || $past(prot_reg))
    else $error("otp byte changed");
  chk_otp_program_enable_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_otp_program_enable_on |=> otp_program_enable)
    else $error("program enable not set");
  chk_protected_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_otp_rd && prot_reg && cmd_addr != 13'h1fcf |=> cmd_rvalid && cmd_rdata == 8'h00)
    else $error("protected otp leaked");
  chk_fuse_unlock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_otp_rd && cmd_addr == 13'h1fcf && otp_mem_rd(13'h1fcf) == 8'h00 |=> otp_unlocked)
    else $error("zero fuse did not unlock");
  chk_fuse_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_otp_rd && cmd_addr == 13'h1fcf && otp_mem_rd(13'h1fcf) != 8'h00 |=> !otp_unlocked)
    else $error("nonzero fuse did not lock");
  chk_probe_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == PMB_ST_PROBE_WAIT && ext_ack |=>
    boot_from_ext == ($past(ext_rdata) != 8'h00 && $past(ext_rdata) != 8'hff))
    else $error("boot source wrong");
  chk_cfg_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_we |-> cfg_addr >= 8'h30 && cfg_addr <= 8'h3f)
    else $error("config word outside 48..63");
  chk_return: assert property (@(posedge ref_clk) disable iff (!rst_n)
    core_may_return |-> rom_return_cfg && core_in_rom)
    else $error("return without config bit");

  // boot sequencing checks
  chk_probe_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == PMB_ST_PROBE |-> ext_req && ext_addr == 13'h0000)
    else $error("probe of location 0 missing");
  chk_probe_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == PMB_ST_PROBE_WAIT && !ext_ack |=> state_reg == PMB_ST_PROBE_WAIT)
    else $error("probe left without answer");
  chk_ext_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    boot_done && boot_from_ext && core_fetch && core_pc <= 16'h1fff |-> ext_req)
    else $error("user fetch not sent outside");
  chk_word_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_we |-> cfg_wdata == word_reg)
    else $error("config word assembly wrong");
  chk_word_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(boot_done) |-> word_idx_reg == 4'h0 && byte_cnt_reg == 2'h0)
    else $error("config word count wrong");
  chk_cfg_last: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(boot_done) |-> load_idx_reg == 6'h2f)
    else $error("config area end wrong");
  chk_no_early_return: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !boot_done |-> !core_may_return)
    else $error("return before boot done");

  // otp command and core fetch checks
  chk_otp_program_enable_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_otp_program_enable_off && !cmd_otp_program_enable_on |=> !otp_program_enable)
    else $error("program enable not cleared");
  chk_write_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_otp_wr && !otp_program_enable |=> otp_written_reg == $past(otp_written_reg))
    else $error("otp written without enable");
  chk_read_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd_otp_rd |=> cmd_rvalid)
    else $error("otp read not answered");
  chk_user_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    core_fetch && core_pc <= 16'h1fff && !boot_from_ext |=>
    core_instr == $past(otp_mem_rd(core_pc[12:0])))
    else $error("otp fetch byte wrong");

  // user eeprom checks
  chk_uee_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    uee_fetch && !uee_store |=> uee_rdata == $past(uee_mem[ram_ptr[6:0]]))
    else $error("user eeprom byte wrong");

endmodule : pmb_boot

/* File: testbench/pmb_ext_eeprom.sv */
// external program eeprom model answering byte requests
`timescale 1ns/1ns
module pmb_ext_eeprom (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ext_req,
  input wire logic [12:0] ext_addr,
  input wire logic [7:0] byte0,
  input wire logic [3:0] lat,
  output logic ext_ack,
  output logic [7:0] ext_rdata
);
  logic [3:0] cnt;
  initial begin
    ext_ack = 1'b0;
    ext_rdata = 8'h00;
    cnt = 4'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    ext_ack <= 1'b0;
    // data line keeps moving outside an answer
    ext_rdata <= ~ext_rdata;
    if (!rst_n) cnt <= 4'h0;
    if (rst_n && ext_req && !ext_ack) begin
      if (cnt >= lat) begin
        ext_ack <= 1'b1;
        ext_rdata <= (ext_addr == 13'h0000) ? byte0 : ext_addr[7:0] ^ 8'h3c;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : pmb_ext_eeprom

/* File: testbench/test_pmb_boot.sv */
// self-checking bench for the boot select and program memory block
`timescale 1ns/1ns
module test_pmb_boot
  import pmb_pkg::*;
;
  logic ref_clk, rst_n, core_fetch, core_in_rom, core_reserved, rom_return_cfg;
  logic core_may_return, ext_req, ext_ack, cmd_otp_program_enable_on, cmd_otp_program_enable_off, cmd_otp_wr;
  logic cmd_otp_rd, cmd_rvalid, otp_program_enable, otp_unlocked, cfg_we, boot_done;
  logic boot_from_ext, uee_store, uee_fetch;
  logic [15:0] core_pc;
  logic [12:0] ext_addr, cmd_addr;
  logic [7:0] rom_rdata, core_instr, ext_rdata, cmd_wdata, cmd_rdata, cfg_addr;
  logic [7:0] ram_ptr, uee_wdata, uee_rdata, byte0;
  logic [23:0] cfg_wdata;
  logic [3:0] lat;
  logic [23:0] cfg_seen [0:255];
  int cfg_cnt, err_total, cmp_count;
  pmb_boot u_pmb_boot (.ref_clk, .rst_n, .core_pc, .core_fetch, .rom_rdata, .core_instr,
    .core_in_rom, .core_reserved, .rom_return_cfg, .core_may_return, .ext_req, .ext_addr,
    .ext_ack, .ext_rdata, .cmd_otp_program_enable_on, .cmd_otp_program_enable_off, .cmd_otp_wr, .cmd_otp_rd, .cmd_addr,
    .cmd_wdata, .cmd_rdata, .cmd_rvalid, .otp_program_enable, .otp_unlocked, .cfg_we,
    .cfg_addr, .cfg_wdata, .boot_done, .boot_from_ext, .ram_ptr, .uee_store, .uee_fetch,
    .uee_wdata, .uee_rdata);
  pmb_ext_eeprom u_pmb_ext_eeprom (.ref_clk, .rst_n, .ext_req, .ext_addr, .byte0, .lat,
    .ext_ack, .ext_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (cfg_we === 1'b1) begin
    cfg_seen[cfg_addr] <= cfg_wdata;
    cfg_cnt <= cfg_cnt + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic pulse_cmd(input int kind, input logic [12:0] a, input logic [7:0] d);
    cmd_addr = a;
    cmd_wdata = d;
    case (kind)
      0: cmd_otp_rd = 1'b1;
      1: cmd_otp_wr = 1'b1;
      2: cmd_otp_program_enable_on = 1'b1;
      default: cmd_otp_program_enable_off = 1'b1;
    endcase
    @(negedge ref_clk);
    {cmd_otp_rd, cmd_otp_wr, cmd_otp_program_enable_on, cmd_otp_program_enable_off} = 4'h0;
  endtask : pulse_cmd
  task automatic otp_rd(input logic [12:0] a, input logic [7:0] exp);
    pulse_cmd(0, a, 8'h00);
    chk(cmd_rvalid, 1'b1);
    chk(cmd_rdata, exp);
    @(negedge ref_clk);
  endtask : otp_rd
  //////////////////////////////////////////////////////////////////////////////
  task automatic boot_case(input logic [7:0] b0, input logic [3:0] l, input logic ext);
    int n;
    logic [7:0] b [0:2];
    rst_n = 1'b0;
    byte0 = b0;
    lat = l;
    cfg_cnt = 0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    n = 0;
    while (boot_done !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      give_verdict();
    end
    repeat (2) @(negedge ref_clk);
    chk(boot_from_ext, ext);
    chk(cfg_cnt, 16);
    if (ext) for (int w = 0; w < 16; w++) begin
      for (int k = 0; k < 3; k++) b[k] = (w + k == 0) ? b0 : 8'(3 * w + k) ^ 8'h3c;
      chk(cfg_seen[PMB_CFG_RAM_BASE + 8'(w)], {b[0], b[1], b[2]});
    end
  endtask : boot_case
  task automatic map_case;
    logic [15:0] pcs [0:5] = '{16'h0000, 16'h1fff, 16'h2000, 16'hefff, 16'hf000, 16'hffff};
    logic [1:0] exp [0:5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    for (int i = 0; i < 6; i++) begin
      core_pc = pcs[i];
      #1;
      chk({core_in_rom, core_reserved}, exp[i]);
    end
  endtask : map_case
  task automatic rom_case;
    core_pc = 16'hf123;
    rom_rdata = 8'h96;
    core_fetch = 1'b1;
    #1;
    chk(core_may_return, 1'b0);
    @(negedge ref_clk);
    core_fetch = 1'b0;
    chk(core_instr, 8'h96);
    rom_return_cfg = 1'b1;
    #1;
    chk(core_may_return, 1'b1);
    core_pc = 16'h0100;
    #1;
    chk(core_may_return, 1'b0);
  endtask : rom_case
  task automatic uee_case;
    for (int i = 0; i < 4; i++) begin
      ram_ptr = 8'h05 + 8'((i % 2) * 8'h40);
      uee_wdata = 8'(8'h5a << (i % 2));
      uee_store = (i < 2);
      uee_fetch = (i >= 2);
      @(negedge ref_clk);
      {uee_store, uee_fetch} = 2'h0;
      if (i >= 2) chk(uee_rdata, 8'(8'h5a << (i % 2)));
      @(negedge ref_clk);
    end
  endtask : uee_case
  task automatic otp_case;
    otp_rd(13'd100, 8'h00);
    chk(otp_unlocked, 1'b0);
    otp_rd(PMB_FUSE_ADDR, 8'h00);
    @(negedge ref_clk);
    chk(otp_unlocked, 1'b1);
    pulse_cmd(1, 13'd100, 8'h3c);
    otp_rd(13'd100, 8'h00);
    pulse_cmd(2, 13'd0, 8'h00);
    chk(otp_program_enable, 1'b1);
    pulse_cmd(1, 13'd100, 8'h3c);
    pulse_cmd(1, 13'd100, 8'hc3);
    otp_rd(13'd100, 8'h3c);
    pulse_cmd(1, PMB_FUSE_ADDR, 8'h01);
    chk(otp_unlocked, 1'b1);
    otp_rd(PMB_FUSE_ADDR, 8'h01);
    @(negedge ref_clk);
    chk(otp_unlocked, 1'b0);
    otp_rd(13'd100, 8'h00);
    pulse_cmd(3, 13'd0, 8'h00);
    chk(otp_program_enable, 1'b0);
  endtask : otp_case
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, core_fetch, rom_return_cfg, cmd_otp_program_enable_on, cmd_otp_program_enable_off, cmd_otp_wr} = '0;
    {cmd_otp_rd, uee_store, uee_fetch, core_pc, cmd_addr, rom_rdata, cmd_wdata} = '0;
    {ram_ptr, uee_wdata, byte0, lat, err_total, cmp_count, cfg_cnt} = '0;
    boot_case(8'h00, 4'h0, 1'b0);
    boot_case(8'hff, 4'h2, 1'b0);
    boot_case(8'h5a, 4'h3, 1'b1);
    map_case();
    rom_case();
    uee_case();
    otp_case();
    give_verdict();
  end
endmodule : test_pmb_boot
